/* core/power_mode_pkg.sv */
package power_mode_pkg;
  // Byte offsets on the register bus
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_MODE = 4'h8;
  // Control register fields
  localparam int POS_PSM = 0;
  localparam int POS_IDLE = 1;
  localparam int POS_HALT = 2;
  localparam int POS_WAIT_GATE = 3;
  localparam int POS_MAIN_OFF = 4;
  localparam int POS_PLL_OFF = 5;
  localparam int POS_HF_OFF = 6;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Status register fields
  localparam int POS_SLOW_OK = 0;
  localparam int POS_MAIN_OK = 1;
  localparam int POS_PLL_OK = 2;
  localparam logic [4:0] STATUS_UPPER = 5'h00;
  // Synchroniser lanes
  localparam int SYNC_W = 6;
  localparam int SY_SLOW = 0;
  localparam int SY_MAIN = 1;
  localparam int SY_PLL = 2;
  localparam int SY_XTAL = 3;
  localparam int SY_NMI = 4;
  localparam int SY_WAKE = 5;
  // Mode codes as seen by software
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_PSAVE = 2'h1;
  localparam logic [1:0] MODE_IDLE = 2'h2;
  localparam logic [1:0] MODE_HALT = 2'h3;
  // Controller states
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_PSAVE = 3'b001,
    ST_IDLE = 3'b010,
    ST_HALT = 3'b011,
    ST_WAKE_MAIN = 3'b100,
    ST_WAKE_PLL = 3'b101,
    ST_EXIT_PS = 3'b110
  } pm_state_t;
endpackage

/* core/power_mode_switch_controller.sv */
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Operation
// - No low-power entry without stable slow oscillator
// - Active entry waits for main oscillator
// - Disabled PLL reports pll_ok set
// - Unstable enabled PLL blocks Active entry
// - Status upper bits zero, lower bits live
// - Wake event latched until acknowledge or reset
// - Wake restores Active, does not resume code
// - Ungated power_save_req switches at once
// - Gated power_save_req reads one immediately
// - Idle needs bit plus WAIT, gated only from Active
// - Halt needs bit plus WAIT, gated only from Active
// - HF clock off only after entry
// - HF on in Active, off in Halt
// - Writing zero leaves Power Save, bit holds
// - NMI or wake input exits to Active
// - Wake sequence: main, wait, PLL, wait
// - Transition stalls until required status set
// - No crystal: main clock stops only in Halt
// - No crystal: Active with slow from main
// - Wake clears idle bit and power_save_req
// - Halt bit cleared after oscillator stable
module power_mode_switch_controller (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic slow_osc_stable,
  input wire logic main_osc_stable,
  input wire logic pll_lock,
  input wire logic slow_crystal_in,
  input wire logic nmi_req,
  input wire logic wake_req,
  input wire logic pll_power_down,
  input wire logic wait_exec,
  input wire logic int_ack,
  output logic main_osc_en,
  output logic pll_en,
  output logic sys_clk_en,
  output logic slow_clk_en,
  output logic slow_from_main,
  output logic [1:0] power_mode,
  output logic wake_pending
);
  // Two-stage synchronisers for pin inputs
  logic [power_mode_pkg::SYNC_W-1:0] sync1_ff; // First stage, read by second only
  logic [power_mode_pkg::SYNC_W-1:0] sync2_ff; // Usable synchronised levels
  wire [power_mode_pkg::SYNC_W-1:0] sync_in = {wake_req, nmi_req, slow_crystal_in,
                                               pll_lock, main_osc_stable, slow_osc_stable};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= sync_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Control and state flops
  power_mode_pkg::pm_state_t st_ff, nxt_st; // Mode state machine
  logic psm_ff, nxt_psm; // power_save_req as software reads it
  logic ps_pend_ff, nxt_ps_pend; // Power Save requested, not yet entered
  logic exit_ff, nxt_exit; // Software asked to leave Power Save
  logic idle_ff, nxt_idle;
  logic halt_ff, nxt_halt;
  logic wg_ff, nxt_wg; // wait_gate
  logic dmc_ff, nxt_dmc; // main_osc_off
  logic dhc_ff, nxt_dhc; // pll_off
  logic dhf_ff, nxt_dhf; // hf_clock_off
  logic armed_ff, nxt_armed; // WAIT seen with a gated request waiting
  logic wake_ff; // Latched wake event
  logic nmi_d_ff, wake_d_ff; // Edge detect on synchronised wake sources
  logic wr_ff; // Registered waitrequest
  logic [31:0] rd_ff; // Registered read data
  logic main_en_ff, pll_en_ff, sys_en_ff, slow_en_ff, from_main_ff;
  logic [1:0] mode_ff;

  // Clock health, crystal absence uses the main clock as slow source
  wire no_xtal = ~sync2_ff[power_mode_pkg::SY_XTAL];
  wire main_ok = sync2_ff[power_mode_pkg::SY_MAIN];
  wire slow_ok = no_xtal ? main_ok : sync2_ff[power_mode_pkg::SY_SLOW];
  wire pll_ok = pll_en_ff ? sync2_ff[power_mode_pkg::SY_PLL] : 1'b1;
  // Upper bits are constant, so writes cannot reach them
  wire [7:0] status = {power_mode_pkg::STATUS_UPPER, pll_ok, main_ok, slow_ok};
  wire [7:0] control = {1'b0, dhf_ff, dhc_ff, dmc_ff, wg_ff, halt_ff, idle_ff, psm_ff};

  // Bus decode: access completes on the cycle waitrequest is low
  wire req = avs_read | avs_write;
  wire done = req & ~wr_ff;
  wire wr_ctl = done & avs_write & avs_byteenable[0]
              & (avs_address == power_mode_pkg::OFS_CONTROL);
  wire [7:0] wd = avs_writedata[7:0];
  wire wd_psm = wd[power_mode_pkg::POS_PSM];
  wire wd_wg = wd[power_mode_pkg::POS_WAIT_GATE];
  wire [31:0] rd_mux = (avs_address == power_mode_pkg::OFS_CONTROL) ? {24'h0, control} :
                       (avs_address == power_mode_pkg::OFS_STATUS) ? {24'h0, status} :
                       (avs_address == power_mode_pkg::OFS_MODE) ? {30'h0, mode_ff} :
                       32'h0; // Unmapped reads give zero

  // Mode decode
  wire in_active = (st_ff == power_mode_pkg::ST_ACTIVE);
  wire in_psave = (st_ff == power_mode_pkg::ST_PSAVE);
  wire in_low = in_psave | (st_ff == power_mode_pkg::ST_IDLE)
              | (st_ff == power_mode_pkg::ST_HALT);
  // Any wake acts only from a low-power mode
  wire wake_go = wake_ff & in_low;
  wire wake_set = (sync2_ff[power_mode_pkg::SY_NMI] & ~nmi_d_ff)
                | (sync2_ff[power_mode_pkg::SY_WAKE] & ~wake_d_ff);
  // Gated entries need the WAIT strobe; from Active also wait_gate
  wire gate_ok = in_psave | (in_active & wg_ff);
  wire go_halt = armed_ff & halt_ff & gate_ok;
  wire go_idle = armed_ff & idle_ff & gate_ok;
  wire go_ps_wait = armed_ff & ps_pend_ff & in_active & wg_ff;
  wire go_ps_now = ps_pend_ff & in_active & ~wg_ff;
  wire arm_req = halt_ff | idle_ff | (ps_pend_ff & wg_ff);

  // Next state and control bit updates
  always_comb
  begin
    nxt_st = st_ff;
    nxt_psm = psm_ff;
    nxt_ps_pend = ps_pend_ff;
    nxt_exit = exit_ff;
    nxt_idle = idle_ff;
    nxt_halt = halt_ff;
    nxt_wg = wg_ff;
    nxt_dmc = dmc_ff;
    nxt_dhc = dhc_ff;
    nxt_dhf = dhf_ff;
    // A WAIT that the gate refuses is dropped, so it cannot fire a later entry
    nxt_armed = armed_ff | (wait_exec & gate_ok & arm_req);
    // Software writes to the control register
    if (wr_ctl)
    begin
      // New settings need a fresh WAIT; no stale arm survives a write
      nxt_armed = 1'b0;
      nxt_idle = wd[power_mode_pkg::POS_IDLE];
      nxt_halt = wd[power_mode_pkg::POS_HALT];
      nxt_wg = wd_wg;
      nxt_dmc = wd[power_mode_pkg::POS_MAIN_OFF];
      nxt_dhc = wd[power_mode_pkg::POS_PLL_OFF];
      nxt_dhf = wd[power_mode_pkg::POS_HF_OFF];
      if (wd_psm & in_active)
      begin
        nxt_ps_pend = 1'b1;
        nxt_psm = wd_wg;
      end
      else if (~wd_psm & in_psave)
        nxt_exit = 1'b1;
      else if (~wd_psm & in_active)
      begin
        // Cancel a request not yet taken
        nxt_ps_pend = 1'b0;
        nxt_psm = 1'b0;
      end
    end
    case (st_ff)
      power_mode_pkg::ST_ACTIVE:
      begin
        // Low-power entries stall while slow clock is unstable
        if (slow_ok)
        begin
          if (go_halt)
            nxt_st = power_mode_pkg::ST_HALT;
          else if (go_idle)
            nxt_st = power_mode_pkg::ST_IDLE;
          else if (go_ps_wait | go_ps_now)
          begin
            nxt_st = power_mode_pkg::ST_PSAVE;
            nxt_psm = 1'b1;
            nxt_ps_pend = 1'b0;
            nxt_armed = 1'b0;
          end
          if (go_halt | go_idle)
            nxt_armed = 1'b0;
        end
      end
      power_mode_pkg::ST_PSAVE, power_mode_pkg::ST_IDLE, power_mode_pkg::ST_HALT:
      begin
        if (wake_go)
        begin
          // Hardware wake: release main oscillator first
          nxt_st = power_mode_pkg::ST_WAKE_MAIN;
          nxt_dmc = 1'b0;
          nxt_idle = 1'b0;
          nxt_psm = 1'b0;
          nxt_ps_pend = 1'b0;
          nxt_exit = 1'b0;
          nxt_armed = 1'b0;
        end
        else if (in_psave & slow_ok & (go_halt | go_idle))
        begin
          nxt_st = go_halt ? power_mode_pkg::ST_HALT : power_mode_pkg::ST_IDLE;
          nxt_armed = 1'b0;
        end
        else if (in_psave & exit_ff)
          nxt_st = power_mode_pkg::ST_EXIT_PS;
      end
      power_mode_pkg::ST_WAKE_MAIN:
      begin
        // Wait for main oscillator, then release the PLL
        if (main_ok)
        begin
          nxt_st = power_mode_pkg::ST_WAKE_PLL;
          nxt_dhc = 1'b0;
        end
      end
      power_mode_pkg::ST_WAKE_PLL:
      begin
        if (main_ok & pll_ok)
        begin
          nxt_st = power_mode_pkg::ST_ACTIVE;
          nxt_halt = 1'b0;
        end
      end
      power_mode_pkg::ST_EXIT_PS:
      begin
        // power_save_req keeps reading one until Active is reached
        if (main_ok & pll_ok)
        begin
          nxt_st = power_mode_pkg::ST_ACTIVE;
          nxt_psm = 1'b0;
          nxt_exit = 1'b0;
        end
      end
      default:
        nxt_st = power_mode_pkg::ST_ACTIVE;
    endcase
  end

  // Clock enables follow the next mode so they line up with st_ff
  wire nxt_psi = (nxt_st == power_mode_pkg::ST_PSAVE) | (nxt_st == power_mode_pkg::ST_IDLE);
  wire nxt_is_halt = (nxt_st == power_mode_pkg::ST_HALT);
  // Disable bits only bite once inside Power Save or Idle; no crystal keeps main on
  wire nxt_main_en = nxt_is_halt ? 1'b0 :
                     nxt_psi ? (no_xtal | ~(nxt_dmc | nxt_dhf)) :
                     1'b1;
  wire nxt_pll_en = (nxt_is_halt | pll_power_down) ? 1'b0 :
                    (nxt_st == power_mode_pkg::ST_WAKE_MAIN) ? (pll_en_ff & ~nxt_dhc) :
                    nxt_psi ? ~nxt_dhc : 1'b1;
  wire nxt_sys_en = ~(nxt_is_halt | (nxt_st == power_mode_pkg::ST_IDLE));
  wire [1:0] nxt_mode = (nxt_st == power_mode_pkg::ST_PSAVE) ? power_mode_pkg::MODE_PSAVE :
                        (nxt_st == power_mode_pkg::ST_IDLE) ? power_mode_pkg::MODE_IDLE :
                        nxt_is_halt ? power_mode_pkg::MODE_HALT : power_mode_pkg::MODE_ACTIVE;

  // Mode machine and control register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= power_mode_pkg::ST_ACTIVE;
      {dhf_ff, dhc_ff, dmc_ff, wg_ff} <= power_mode_pkg::CONTROL_RESET[6:3];
      {halt_ff, idle_ff, psm_ff} <= power_mode_pkg::CONTROL_RESET[2:0];
      ps_pend_ff <= 1'b0;
      exit_ff <= 1'b0;
      armed_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      {dhf_ff, dhc_ff, dmc_ff, wg_ff} <= {nxt_dhf, nxt_dhc, nxt_dmc, nxt_wg};
      {halt_ff, idle_ff, psm_ff} <= {nxt_halt, nxt_idle, nxt_psm};
      ps_pend_ff <= nxt_ps_pend;
      exit_ff <= nxt_exit;
      armed_ff <= nxt_armed;
    end
  end

  // Wake latch: a new event beats a same-cycle acknowledge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wake_ff <= 1'b0;
      nmi_d_ff <= 1'b0;
      wake_d_ff <= 1'b0;
    end
    else
    begin
      wake_ff <= wake_set | (wake_ff & ~int_ack);
      nmi_d_ff <= sync2_ff[power_mode_pkg::SY_NMI];
      wake_d_ff <= sync2_ff[power_mode_pkg::SY_WAKE];
    end
  end

  // Clock outputs; no crystal means slow clock comes from main
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      main_en_ff <= 1'b1;
      pll_en_ff <= 1'b1;
      sys_en_ff <= 1'b1;
      slow_en_ff <= 1'b1;
      from_main_ff <= 1'b0;
      mode_ff <= power_mode_pkg::MODE_ACTIVE;
    end
    else
    begin
      main_en_ff <= nxt_main_en;
      pll_en_ff <= nxt_pll_en;
      sys_en_ff <= nxt_sys_en;
      slow_en_ff <= ~nxt_is_halt;
      from_main_ff <= no_xtal;
      mode_ff <= nxt_mode;
    end
  end

  // Avalon slave: one wait cycle, then completion
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ff <= 1'b1;
      rd_ff <= 32'h0;
    end
    else
    begin
      wr_ff <= ~(req & wr_ff);
      rd_ff <= rd_mux;
    end
  end

  assign avs_waitrequest = wr_ff;
  assign avs_readdata = rd_ff;
  assign main_osc_en = main_en_ff;
  assign pll_en = pll_en_ff;
  assign sys_clk_en = sys_en_ff;
  assign slow_clk_en = slow_en_ff;
  assign slow_from_main = from_main_ff;
  assign power_mode = mode_ff;
  assign wake_pending = wake_ff;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_lowpower_slow_ok: assert property (in_active && nxt_st != power_mode_pkg::ST_ACTIVE
    |-> slow_ok) else $error("low-power entry with unstable slow clock");
  a_active_clocks_ok: assert property (!in_active && nxt_st == power_mode_pkg::ST_ACTIVE
    |-> main_ok && pll_ok) else $error("Active entered with unstable clock");
  a_pll_off_ok: assert property (!pll_en_ff |-> status[2])
    else $error("disabled PLL blocks status");
  a_status_upper: assert property (status[7:3] == 5'h00)
    else $error("status upper bits not zero");
  a_wake_held: assert property (wake_ff && !int_ack |=> wake_ff)
    else $error("wake latch lost");
  a_gated_psm: assert property (wr_ctl && wd_psm && wd_wg && in_active |=> psm_ff)
    else $error("gated request not readable");
  a_hf_mode_force: assert property ((in_active |-> main_en_ff) and
    (st_ff == power_mode_pkg::ST_HALT |-> !main_en_ff)) else $error("HF enable wrong");
  a_wake_main_wait: assert property (st_ff == power_mode_pkg::ST_WAKE_MAIN && !main_ok
    |=> st_ff == power_mode_pkg::ST_WAKE_MAIN) else $error("wake skipped oscillator wait");
  a_psave_reads_one: assert property (in_psave || st_ff == power_mode_pkg::ST_EXIT_PS
    |-> psm_ff) else $error("power_save_req dropped early");
  a_noxtal_main_on: assert property (no_xtal && st_ff != power_mode_pkg::ST_HALT
    |=> main_en_ff || st_ff == power_mode_pkg::ST_HALT) else $error("main clock stopped");
  a_wake_exit: assert property (wake_go |=> st_ff == power_mode_pkg::ST_WAKE_MAIN)
    else $error("wake not taken");

  c_enter_psave: cover property (in_active ##1 in_psave);
  c_enter_halt: cover property (st_ff == power_mode_pkg::ST_HALT);
  c_wake_done: cover property (st_ff == power_mode_pkg::ST_WAKE_PLL ##1 in_active);
  c_sw_exit: cover property (st_ff == power_mode_pkg::ST_EXIT_PS ##1 in_active);
endmodule // power_mode_switch_controller

/* verification/osc_source_model.sv */
`timescale 1ns/1ps
// Oscillator and PLL behind the clock enables: each settles some cycles after enable
module osc_source_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic main_osc_en,
  input wire logic pll_en,
  input wire logic [7:0] settle,
  output logic main_osc_stable,
  output logic pll_lock
);
  logic [7:0] main_cnt_ff; // Cycles since main oscillator enable
  logic [7:0] pll_cnt_ff; // Cycles since PLL enable with a stable reference
  logic [7:0] nxt_main_cnt;
  logic [7:0] nxt_pll_cnt;
  // Stability drops at once on disable, so a stale high never hides a restart
  assign main_osc_stable = main_osc_en && (main_cnt_ff >= settle);
  assign pll_lock = pll_en && main_osc_stable && (pll_cnt_ff >= settle);
  assign nxt_main_cnt = !main_osc_en ? 8'h00 : (main_osc_stable ? main_cnt_ff : main_cnt_ff + 8'h01);
  assign nxt_pll_cnt = !(pll_en && main_osc_stable) ? 8'h00 : (pll_lock ? pll_cnt_ff : pll_cnt_ff + 8'h01);
  // Settling counters
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      main_cnt_ff <= 8'h00;
      pll_cnt_ff <= 8'h00;
    end
    else
    begin
      main_cnt_ff <= nxt_main_cnt;
      pll_cnt_ff <= nxt_pll_cnt;
    end
  end
endmodule // osc_source_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic slow_osc_stable, main_osc_stable, pll_lock, slow_crystal_in, pll_power_down;
  logic [3:0] pulses; // Strobes: wait_exec, int_ack, wake_req, nmi_req
  logic main_osc_en, pll_en, sys_clk_en, slow_clk_en, slow_from_main, wake_pending;
  logic [1:0] power_mode;
  logic [7:0] settle; // Oscillator settling time in cycles
  int miscompares, n_compared, cycles, i;

  power_mode_switch_controller u_dut (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .slow_osc_stable(slow_osc_stable), .main_osc_stable(main_osc_stable),
    .pll_lock(pll_lock), .slow_crystal_in(slow_crystal_in), .nmi_req(pulses[3]),
    .wake_req(pulses[2]), .pll_power_down(pll_power_down), .wait_exec(pulses[0]),
    .int_ack(pulses[1]), .main_osc_en(main_osc_en), .pll_en(pll_en),
    .sys_clk_en(sys_clk_en), .slow_clk_en(slow_clk_en), .slow_from_main(slow_from_main),
    .power_mode(power_mode), .wake_pending(wake_pending)
  );
  osc_source_model u_osc (
    .clk_sys(clk_sys), .rst(rst), .main_osc_en(main_osc_en), .pll_en(pll_en),
    .settle(settle), .main_osc_stable(main_osc_stable), .pll_lock(pll_lock)
  );

  // 250 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize;
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bit_chk(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  // One bus access; request held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_read <= !wr;
    avs_write <= wr;
    // Only the bench timeout ends a wait that never answers
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    access(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask

  // Repeated reads until a field settles, bounded
  task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    for (n = 0; n < 60; n++)
    begin
      access(1'b0, a, 32'h0);
      if ((rd & m) === e)
        break;
    end
    check(rd & m, e);
  endtask

  task automatic wait_mode(input logic [1:0] m);
    int n;
    for (n = 0; n < 300 && power_mode !== m; n++)
      @(posedge clk_sys);
    check({30'h0, power_mode}, {30'h0, m});
  endtask

  // One-cycle strobe on a CPU or wake line
  task automatic pulse(input int k);
    @(posedge clk_sys);
    pulses[k] <= 1'b1;
    @(posedge clk_sys);
    pulses[k] <= 1'b0;
  endtask

  initial
  begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {slow_osc_stable, pll_power_down, pulses} = '0;
    slow_crystal_in = 1'b1;
    settle = 8'h14;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (60) @(posedge clk_sys);
    // Status after reset, write ignored, unmapped place
    rd_chk(power_mode_pkg::OFS_STATUS, 32'hffffffff, 32'h6);
    access(1'b1, power_mode_pkg::OFS_STATUS, 32'hff);
    rd_chk(power_mode_pkg::OFS_STATUS, 32'hffffffff, 32'h6);
    rd_chk(4'hc, 32'hffffffff, 32'h0);
    // Power Save request stalls while slow oscillator unstable
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h01);
    repeat (20) @(posedge clk_sys);
    check({30'h0, power_mode}, 32'h0);
    rd_chk(power_mode_pkg::OFS_CONTROL, 32'h1, 32'h0);
    slow_osc_stable <= 1'b1;
    poll(power_mode_pkg::OFS_STATUS, 32'h7, 32'h7);
    wait_mode(power_mode_pkg::MODE_PSAVE);
    rd_chk(power_mode_pkg::OFS_CONTROL, 32'h1, 32'h1);
    // Main oscillator off in Power Save, restarted before the exit
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h11);
    repeat (3) @(posedge clk_sys);
    bit_chk(main_osc_en, 1'b0);
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h01);
    poll(power_mode_pkg::OFS_STATUS, 32'h2, 32'h2);
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h00);
    rd_chk(power_mode_pkg::OFS_CONTROL, 32'h1, 32'h1);
    poll(power_mode_pkg::OFS_CONTROL, 32'h1, 32'h0);
    bit_chk(main_osc_stable, 1'b1);
    // Gated Power Save with hf_clock_off, then Idle from Power Save
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h48);
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h49);
    rd_chk(power_mode_pkg::OFS_CONTROL, 32'h1, 32'h1);
    check({30'h0, power_mode}, 32'h0);
    bit_chk(main_osc_en, 1'b1);
    pulse(0);
    wait_mode(power_mode_pkg::MODE_PSAVE);
    repeat (3) @(posedge clk_sys);
    bit_chk(main_osc_en, 1'b0);
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h43);
    pulse(0);
    wait_mode(power_mode_pkg::MODE_IDLE);
    // Wake from Idle; latch holds until acknowledge
    pulse(2);
    poll(power_mode_pkg::OFS_CONTROL, 32'h3, 32'h0);
    check({30'h0, power_mode}, 32'h0);
    bit_chk(sys_clk_en, 1'b1);
    repeat (10) @(posedge clk_sys);
    bit_chk(wake_pending, 1'b1);
    pulse(1);
    repeat (2) @(posedge clk_sys);
    bit_chk(wake_pending, 1'b0);
    // Let the wake sequence reach Active before the refusal test
    repeat (60) @(posedge clk_sys);
    // Idle without wait_gate from Active is refused
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h02);
    pulse(0);
    repeat (10) @(posedge clk_sys);
    check({30'h0, power_mode}, 32'h0);
    // Halt, then NMI wake with slow settling
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h08);
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h0c);
    repeat (4) @(posedge clk_sys);
    check({30'h0, power_mode}, 32'h0);
    pulse(0);
    wait_mode(power_mode_pkg::MODE_HALT);
    bit_chk(main_osc_en | pll_en | sys_clk_en, 1'b0);
    bit_chk(slow_clk_en, 1'b0);
    settle <= 8'h28;
    pulse(3);
    for (i = 0; i < 100 && main_osc_en !== 1'b1; i++) @(posedge clk_sys);
    bit_chk(pll_en, 1'b0);
    rd_chk(power_mode_pkg::OFS_CONTROL, 32'h4, 32'h4);
    for (i = 0; i < 100 && pll_en !== 1'b1; i++) @(posedge clk_sys);
    bit_chk(main_osc_stable, 1'b1);
    rd_chk(power_mode_pkg::OFS_STATUS, 32'h4, 32'h0);
    poll(power_mode_pkg::OFS_CONTROL, 32'h4, 32'h0);
    bit_chk(pll_lock & main_osc_en, 1'b1);
    bit_chk(slow_clk_en, 1'b1);
    check({30'h0, power_mode}, 32'h0);
    pulse(1);
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h00);
    // PLL forced down reads as stable
    pll_power_down <= 1'b1;
    repeat (5) @(posedge clk_sys);
    bit_chk(pll_en, 1'b0);
    rd_chk(power_mode_pkg::OFS_STATUS, 32'h4, 32'h4);
    pll_power_down <= 1'b0;
    settle <= 8'h14;
    // No slow crystal: main clock kept in Power Save, stopped in Halt
    slow_crystal_in <= 1'b0;
    repeat (8) @(posedge clk_sys);
    bit_chk(slow_from_main, 1'b1);
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h19);
    pulse(0);
    wait_mode(power_mode_pkg::MODE_PSAVE);
    repeat (5) @(posedge clk_sys);
    bit_chk(main_osc_en, 1'b1);
    access(1'b1, power_mode_pkg::OFS_CONTROL, 32'h0d);
    pulse(0);
    wait_mode(power_mode_pkg::MODE_HALT);
    bit_chk(main_osc_en, 1'b0);
    pulse(2);
    poll(power_mode_pkg::OFS_CONTROL, 32'h4, 32'h0);
    bit_chk(slow_from_main & main_osc_en, 1'b1);
    check({30'h0, power_mode}, 32'h0);
    summarize();
  end
endmodule // tb
